// *** logic/net_busy_pkg.sv ***
// shared types and constants for the radio net busy interface
package net_busy_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int FH_DETECT_MS = 350;
  localparam int SC_DETECT_MS = 100;
  localparam int VOICE_ASSUME_MS = 750;
  localparam int CLK_IDLE_US = 500;
  localparam int FH_DETECT_CYC = FH_DETECT_MS * (CLK_HZ / 1000);
  localparam int SC_DETECT_CYC = SC_DETECT_MS * (CLK_HZ / 1000);
  localparam int VOICE_ASSUME_CYC = VOICE_ASSUME_MS * (CLK_HZ / 1000);
  localparam int CLK_IDLE_CYC = CLK_IDLE_US * (CLK_HZ / 1000_000);
  localparam int SYNC_FLAGS = 4;
  localparam logic [7:0] FLAG_BYTE = 8'h7E;
  localparam logic [2:0] SLOT_OFFSET_T3 = 3'h0;
  localparam logic [2:0] SLOT_LIMIT_T3 = 3'h0;
  localparam logic [2:0] RATE_600 = 3'h0;
  localparam logic [2:0] RATE_1200 = 3'h1;
  localparam logic [2:0] RATE_2400 = 3'h2;
  localparam logic [2:0] RATE_4800 = 3'h3;
  localparam logic [2:0] RATE_16000 = 3'h4;

  typedef enum logic [2:0] {
    NET_IDLE = 3'b000,
    NET_BUSY = 3'b001,
    NET_VOICE = 3'b010,
    NET_DATA = 3'b011,
    NET_NA = 3'b100
  } net_status_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_FLAGS = 2'b01,
    TX_DATA = 2'b10,
    TX_TRAIL = 2'b11
  } tx_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic type3;
  } tx_word_t;

  typedef struct packed {
    logic [2:0] slotOffset;
    logic [2:0] slotLimit;
    logic immediate;
  } access_t;
endpackage

// *** logic/radio_net_busy_interface.sv ***
// terminal side of the radio link: net status decode, flag sync and transmit
// Operation
// RL1 - type 3 units and their acks get a slot offset of zero and a slot count of zero.
// RL2 - type 3 units and their acks are sent in immediate mode with no random delay.
// RL3 - the radio passes trailing flags unchanged over the air.
// RL4 - appended trailing flags count toward the transmission length.
// RL5 - receive sync is reached within four flags and data may start after a valid flag.
// RL6 - the link is synchronous half-duplex serial with NRZ signalling.
// RL7 - rates 600, 1200, 2400, 4800 and 16000 bps are supported, same on both sides.
// RL8 - below 16000 bps the radio adapts the rate with majority-logic correction.
// RL9 - the radio drives squelch whenever it senses channel activity.
// RL10 - the channel counts busy within 350 ms hop or 100 ms single-channel of squelch.
// RL11 - the radio supplies a receive clock for data, after or with squelch.
// RL12 - in voice reception the radio asserts squelch without the receive clock.
// RL13 - squelch plus clock is data, squelch alone voice, neither idle.
// RL14 - busy with receive line at ones turns voice after 750 ms, flags mean data.
// RL15 - transmit checks idle, raises push-to-talk, sends flags, data, then idles at ones.
// RL16 - no transmission starts while status is voice, data or unresolved busy.
`timescale 1ns/1ps
module radio_net_busy_interface
  import net_busy_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic hopMode,
  input wire logic [2:0] rateSel,
  input wire logic receive_squelch_n,
  input wire logic receive_data_clock_out,
  input wire logic rxData,
  input wire net_busy_pkg::tx_word_t txWord,
  input wire logic txValid,
  output logic txReady,
  input wire logic [3:0] trailFlags,
  input wire logic txClk,
  output logic txData,
  output logic pushToTalk,
  output net_busy_pkg::net_status_t netStatus,
  output logic channelBusy,
  output logic rxSynced,
  output net_busy_pkg::access_t accessCfg,
  output logic [15:0] txLength,
  output logic rateOk
);
  import net_busy_pkg::*;

  logic rstMeta_ff, rstSync_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end
  wire logic rst = ~rstSync_ff;

  // two-flop synchronisers for every pin input
  logic [4:0] pinMeta_ff, pinSync_ff, pinPrev_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // transmit clock resets to its idle low level, no false fall
      pinMeta_ff <= 5'h0F;
      pinSync_ff <= 5'h0F;
      pinPrev_ff <= 5'h0F;
    end else begin
      pinMeta_ff <= {txClk, rxData, receive_data_clock_out, receive_squelch_n, 1'b1};
      pinSync_ff <= pinMeta_ff;
      pinPrev_ff <= pinSync_ff;
    end
  end
  wire logic sqActive = ~pinSync_ff[1];
  wire logic rxClkRise = pinSync_ff[2] & ~pinPrev_ff[2];
  wire logic rxBit = pinSync_ff[3];
  wire logic txClkFall = ~pinSync_ff[4] & pinPrev_ff[4];

  function automatic logic [27:0] sat_inc(input logic [27:0] v);
    sat_inc = (v == 28'hFFF_FFFF) ? v : v + 28'h000_0001;
  endfunction

  logic pttPrev_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pttPrev_ff <= 1'b0;
    else pttPrev_ff <= pushToTalk;
  end
  wire logic ownTxEnd = pttPrev_ff && !pushToTalk;

  // receive clock is active while edges keep arriving
  logic [27:0] clkIdle_ff;
  logic rxClkActive_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clkIdle_ff <= 28'h000_0000;
      rxClkActive_ff <= 1'b0;
    end else if (rxClkRise) begin
      clkIdle_ff <= 28'h000_0000;
      rxClkActive_ff <= 1'b1;
    end else if (ownTxEnd) begin
      // echo clock of our own frame ends with it
      clkIdle_ff <= 28'h000_0000;
      rxClkActive_ff <= 1'b0;
    end else begin
      clkIdle_ff <= sat_inc(clkIdle_ff);
      if (clkIdle_ff >= 28'(CLK_IDLE_CYC)) rxClkActive_ff <= 1'b0;
    end
  end

  // flag hunting on the receive line
  logic [7:0] rxShift_ff;
  logic [2:0] flagCnt_ff;
  logic flagSeen_ff;
  wire logic flagHit = rxClkRise && ({rxBit, rxShift_ff[7:1]} == FLAG_BYTE);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxShift_ff <= 8'hFF;
      flagCnt_ff <= 3'h0;
      flagSeen_ff <= 1'b0;
      rxSynced <= 1'b0;
    end else begin
      if (rxClkRise) rxShift_ff <= {rxBit, rxShift_ff[7:1]};
      if (!rxClkActive_ff) begin
        flagCnt_ff <= 3'h0;
        flagSeen_ff <= 1'b0;
        rxSynced <= 1'b0;
      end else if (flagHit) begin
        flagSeen_ff <= 1'b1; // see RL14
        rxSynced <= 1'b1; // see RL5
        if (flagCnt_ff != 3'(SYNC_FLAGS)) flagCnt_ff <= flagCnt_ff + 3'h1;
      end
    end
  end

  // squelch qualification and voice timeout
  logic [27:0] sqCnt_ff;
  wire logic [27:0] detectCyc = hopMode ? 28'(FH_DETECT_CYC) : 28'(SC_DETECT_CYC);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sqCnt_ff <= 28'h000_0000;
    else if (!sqActive) sqCnt_ff <= 28'h000_0000;
    else sqCnt_ff <= sat_inc(sqCnt_ff);
  end

  net_status_t nxt_status;
  always_comb begin
    nxt_status = NET_IDLE;
    if (sqActive && (rxClkActive_ff || flagSeen_ff)) nxt_status = NET_DATA; // see RL13
    else if (sqActive && sqCnt_ff >= 28'(VOICE_ASSUME_CYC)) nxt_status = NET_VOICE; // see RL14
    else if (sqActive) nxt_status = NET_BUSY;
    else if (rxClkActive_ff) nxt_status = NET_NA;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      netStatus <= NET_IDLE;
      channelBusy <= 1'b0;
    end else begin
      netStatus <= nxt_status;
      channelBusy <= sqActive && (sqCnt_ff < detectCyc); // see RL10
    end
  end

  // two-entry buffer in the transmit path
  tx_word_t buf_ff [2];
  logic [1:0] bufCnt_ff;
  logic bufWr_ff, bufRd_ff;
  wire logic pop;
  wire logic push = txValid && (bufCnt_ff != 2'h2);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bufCnt_ff <= 2'h0;
      bufWr_ff <= 1'b0;
      bufRd_ff <= 1'b0;
      txReady <= 1'b0;
    end else begin
      if (push) bufWr_ff <= ~bufWr_ff;
      if (pop) bufRd_ff <= ~bufRd_ff;
      bufCnt_ff <= bufCnt_ff + 2'(push) - 2'(pop);
      txReady <= (bufCnt_ff + 2'(push) - 2'(pop)) < 2'h2;
    end
  end
  always_ff @(posedge clk) begin
    if (push) buf_ff[bufWr_ff] <= txWord;
  end
  wire tx_word_t head = buf_ff[bufRd_ff];
  wire logic bufValid = bufCnt_ff != 2'h0;

  // transmit sequencer, bits change on falling edges of the transmit clock
  tx_state_t txState_ff;
  logic [7:0] txSh_ff;
  logic [2:0] bitCnt_ff;
  logic [3:0] trailCnt_ff;
  logic lastByte_ff, drainWait_ff;
  wire logic netFree = (netStatus == NET_IDLE) && !channelBusy; // see RL16
  wire logic byteDone = txClkFall && bitCnt_ff == 3'h7;
  assign pop = (txState_ff == TX_DATA) && byteDone && !lastByte_ff && bufValid;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txState_ff <= TX_IDLE;
      txSh_ff <= 8'hFF;
      bitCnt_ff <= 3'h0;
      trailCnt_ff <= 4'h0;
      lastByte_ff <= 1'b0;
      drainWait_ff <= 1'b0;
      txData <= 1'b1;
      pushToTalk <= 1'b0;
      txLength <= 16'h0000;
    end else begin
      if (txClkFall) begin
        txData <= txSh_ff[0]; // see RL6
        txSh_ff <= {1'b1, txSh_ff[7:1]};
        bitCnt_ff <= bitCnt_ff + 3'h1;
      end
      case (txState_ff)
        TX_IDLE: begin
          txData <= 1'b1; // see RL15
          pushToTalk <= 1'b0;
          if (bufValid && netFree) begin // see RL15
            txState_ff <= TX_FLAGS;
            pushToTalk <= 1'b1;
            txSh_ff <= FLAG_BYTE;
            bitCnt_ff <= 3'h0;
            lastByte_ff <= 1'b0;
            txLength <= 16'h0000;
          end
        end
        TX_FLAGS: begin
          if (byteDone) begin
            txSh_ff <= FLAG_BYTE;
            if (rxSynced) begin // see RL5
              txState_ff <= TX_DATA;
            end
          end
        end
        TX_DATA: begin
          if (byteDone) begin
            if (lastByte_ff || !bufValid) begin
              txState_ff <= TX_TRAIL;
              trailCnt_ff <= trailFlags;
              txSh_ff <= FLAG_BYTE;
            end else begin
              txSh_ff <= head.data;
              lastByte_ff <= head.last;
              txLength <= txLength + 16'h0001;
            end
          end
        end
        TX_TRAIL: begin
          if (drainWait_ff) begin
            // last flag bit is clocked out before push-to-talk drops
            if (txClkFall) begin
              txState_ff <= TX_IDLE;
              pushToTalk <= 1'b0; // see RL15
              drainWait_ff <= 1'b0;
            end
          end else if (byteDone) begin
            txSh_ff <= FLAG_BYTE;
            if (trailCnt_ff == 4'h0) begin
              drainWait_ff <= 1'b1;
              txSh_ff <= 8'hFF;
            end else begin
              trailCnt_ff <= trailCnt_ff - 4'h1;
              txLength <= txLength + 16'h0001; // see RL4
            end
          end
        end
        default: txState_ff <= TX_IDLE;
      endcase
    end
  end

  // access settings for the head unit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accessCfg <= '0;
      rateOk <= 1'b0;
    end else begin
      accessCfg.immediate <= bufValid && head.type3; // see RL2
      accessCfg.slotOffset <= SLOT_OFFSET_T3; // see RL1
      accessCfg.slotLimit <= SLOT_LIMIT_T3; // see RL1
      rateOk <= rateSel <= RATE_16000; // see RL7
    end
  end

  property p_voice_after_timeout;
    @(posedge clk) disable iff (rst)
      (sqActive && !rxClkActive_ff && !flagSeen_ff && sqCnt_ff >= 28'(VOICE_ASSUME_CYC))
      |=> netStatus == NET_VOICE;
  endproperty
  a_voice_after_timeout: assert property (p_voice_after_timeout) // see RL14
    else $error("voice not reported after timeout");

  property p_data_decode;
    @(posedge clk) disable iff (rst) (sqActive && rxClkActive_ff) |=> netStatus == NET_DATA;
  endproperty
  a_data_decode: assert property (p_data_decode) // see RL13
    else $error("data reception not decoded");

  property p_idle_decode;
    @(posedge clk) disable iff (rst) (!sqActive && !rxClkActive_ff) |=> netStatus == NET_IDLE;
  endproperty
  a_idle_decode: assert property (p_idle_decode) // see RL13
    else $error("idle not decoded");

  property p_busy_quick;
    @(posedge clk) disable iff (rst) $rose(sqActive) |=> channelBusy;
  endproperty
  a_busy_quick: assert property (p_busy_quick) // see RL10
    else $error("busy not flagged on squelch");

  sequence s_start;
    txState_ff == TX_IDLE && bufValid && netFree;
  endsequence
  property p_start_ptt;
    @(posedge clk) disable iff (rst) s_start |=> pushToTalk && txState_ff == TX_FLAGS;
  endproperty
  a_start_ptt: assert property (p_start_ptt) // see RL15
    else $error("push-to-talk not raised");

  property p_no_start_busy;
    @(posedge clk) disable iff (rst)
      (txState_ff == TX_IDLE && netStatus != NET_IDLE) |=> txState_ff != TX_DATA && !pushToTalk;
  endproperty
  a_no_start_busy: assert property (p_no_start_busy) // see RL16
    else $error("transmission started on busy net");

  property p_data_needs_sync;
    @(posedge clk) disable iff (rst)
      (txState_ff == TX_FLAGS && !rxSynced) |=> txState_ff != TX_DATA;
  endproperty
  a_data_needs_sync: assert property (p_data_needs_sync) // see RL5
    else $error("data before flag sync");

  property p_type3_zero;
    @(posedge clk) disable iff (rst)
      (bufValid && head.type3)
      |=> accessCfg.immediate && accessCfg.slotOffset == 3'h0 && accessCfg.slotLimit == 3'h0;
  endproperty
  a_type3_zero: assert property (p_type3_zero) // see RL1
    else $error("nonzero slot setting");
endmodule

// *** verification/radio_model.sv ***
// behavioural radio: bit clocks, squelch pin and receive line
`timescale 1ns/1ps
module radio_model (
  input wire logic pushToTalk,
  input wire logic txData,
  input wire logic squelchOn,
  input wire logic dataOn,
  output logic txClk,
  output logic squelchN,
  output logic rxClk,
  output logic rxData
);
  logic [7:0] pat;
  initial begin
    txClk = 1'b0;
    rxClk = 1'b0;
    rxData = 1'b1;
    pat = 8'h7E;
  end
  assign squelchN = !squelchOn;
  // clocks stand still outside frames; no clock on voice
  // one bench line rate; over-air rate adaption stays inside the radio
  always begin
    #62.5;
    txClk = pushToTalk ? !txClk : 1'b0;
    rxClk = (pushToTalk || dataOn) ? !rxClk : 1'b0;
  end
  // echo of the sent stream untouched, flags on data reception, ones when idle
  always @(negedge rxClk) begin
    pat <= {pat[0], pat[7:1]};
    rxData <= pushToTalk ? txData : (dataOn ? pat[0] : 1'b1);
  end
endmodule

// *** verification/radio_net_busy_interface_tb.sv ***
// self-checking bench for the terminal side of the radio link
`timescale 1ns/1ps
module radio_net_busy_interface_tb;
  import net_busy_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, hopMode = 1'b0, rxData, sqN, rxClk, txClk;
  logic [2:0] rateSel = 3'h0;
  tx_word_t txWord = '0;
  logic txValid = 1'b0, sqOn = 1'b0, dataOn = 1'b0;
  logic [3:0] trailFlags = 4'h0;
  logic txReady, txData, pushToTalk, channelBusy, rxSynced, rateOk;
  net_status_t netStatus;
  access_t accessCfg;
  logic [15:0] txLength;
  int error_cnt = 0, check_count = 0, cnt = 0, k;
  logic [31:0] seed = 32'h500466bf;
  logic [7:0] sh = 8'hFF, q[$];
  logic al = 1'b0;
  always #2.5 clk = !clk;
  radio_net_busy_interface i_radio_net_busy_interface (.clk(clk), .rstn(rstn),
    .hopMode(hopMode), .rateSel(rateSel), .receive_squelch_n(sqN),
    .receive_data_clock_out(rxClk), .rxData(rxData), .txWord(txWord), .txValid(txValid),
    .txReady(txReady), .trailFlags(trailFlags), .txClk(txClk), .txData(txData),
    .pushToTalk(pushToTalk), .netStatus(netStatus), .channelBusy(channelBusy),
    .rxSynced(rxSynced), .accessCfg(accessCfg), .txLength(txLength), .rateOk(rateOk));
  radio_model i_radio_model (.pushToTalk(pushToTalk), .txData(txData), .squelchOn(sqOn),
    .dataOn(dataOn), .txClk(txClk), .squelchN(sqN), .rxClk(rxClk), .rxData(rxData));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // byte-aligned capture of the line, least significant bit first
  always @(posedge txClk) begin
    if (pushToTalk) begin
      sh = {txData, sh[7:1]};
      cnt = cnt + 1;
      if (!al && sh == FLAG_BYTE) begin
        al = 1'b1;
        cnt = 0;
        q.push_back(sh);
      end else if (al && cnt == 8) begin
        cnt = 0;
        q.push_back(sh);
      end
    end
  end
  task automatic chkBit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chkVal(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic frame(input int n, input logic t3);
    logic [7:0] d[$];
    logic [7:0] b;
    logic full, syn;
    logic [15:0] len;
    logic [3:0] tf;
    int i, lead;
    full = 1'b0;
    syn = 1'b0;
    q.delete();
    al = 1'b0;
    seed = lfsr(seed);
    tf = {2'b00, seed[1:0]};
    @(posedge clk);
    trailFlags <= tf;
    for (i = 0; i < n; i++) begin
      seed = lfsr(seed);
      b = (seed[7:0] == FLAG_BYTE) ? 8'h5A : seed[7:0];
      d.push_back(b);
      txWord <= '{data: b, last: (i == n - 1), type3: t3};
      txValid <= 1'b1;
      for (k = 0; k < 5000; k++) begin
        @(negedge clk);
        if (txReady) break;
        full = 1'b1;
      end
      @(posedge clk);
    end
    txValid <= 1'b0;
    @(negedge clk);
    for (k = 0; k < 2000 && !pushToTalk; k++) @(negedge clk);
    chkBit("ptt", 1'b1, pushToTalk);
    chkVal("access", {6'h0, t3}, accessCfg);
    for (k = 0; k < 20000 && pushToTalk; k++) begin
      @(negedge clk);
      syn |= rxSynced;
      len = txLength;
    end
    if (n == 4) chkBit("full", 1'b1, full);
    chkBit("synced", 1'b1, syn);
    chkBit("idle line", 1'b1, txData);
    for (lead = 0; lead < q.size() && q[lead] == FLAG_BYTE; lead++);
    chkBit("lead", 1'b1, lead >= 1 && lead <= SYNC_FLAGS);
    for (i = 0; i < n; i++) chkVal("byte", {8'h0, d[i]}, {8'h0, q[lead + i]});
    chkVal("length", 16'(n) + 16'(tf), len);
    chkVal("trail", 16'(tf) + 16'h0001, 16'(q.size() - lead - n));
  endtask
  initial begin
    #500000;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chkVal("idle", 16'(NET_IDLE), 16'(netStatus));
    for (k = 0; k < 8; k++) begin
      rateSel <= 3'(k);
      repeat (3) @(posedge clk);
      chkBit("rate", k < 5, rateOk);
    end
    rateSel <= RATE_16000;
    frame(4, 1'b1);
    frame(1, 1'b0);
    for (int f = 0; f < 3; f++) frame(1 + int'(seed[3:2]), seed[4]);
    seed = lfsr(seed);
    @(posedge clk);
    hopMode <= seed[0];
    sqOn <= 1'b1;
    for (k = 0; k < 20 && !channelBusy; k++) @(negedge clk);
    chkBit("busy", 1'b1, channelBusy);
    chkVal("unresolved", 16'(NET_BUSY), 16'(netStatus));
    txWord <= '{data: 8'h33, last: 1'b1, type3: 1'b0};
    txValid <= 1'b1;
    @(posedge clk);
    txValid <= 1'b0;
    repeat (400) @(posedge clk);
    chkBit("withheld", 1'b0, pushToTalk);
    dataOn <= 1'b1;
    for (k = 0; k < 2000 && netStatus !== NET_DATA; k++) @(negedge clk);
    chkVal("data", 16'(NET_DATA), 16'(netStatus));
    sqOn <= 1'b0;
    for (k = 0; k < 200 && netStatus !== NET_NA; k++) @(negedge clk);
    chkVal("clock only", 16'(NET_NA), 16'(netStatus));
    summarize();
  end
endmodule
